// >>> rtl/pae_pkg.sv
package pae_pkg;

   // ==========================================================
   // Clock and time base.
   localparam int unsigned CLK_HZ        = 40000000;
   localparam int unsigned HZ_PER_KHZ    = 1000;
   localparam int unsigned MS_CYCLES     = CLK_HZ / HZ_PER_KHZ;
   localparam int unsigned PULSE_MIN_SHORT_MS = 100;
   localparam int unsigned PULSE_MIN_LONG_MS  = 350;
   localparam int unsigned PULSE_MAX_MS       = 30000;
   localparam int          MS_W          = 15;
   localparam logic [MS_W-1:0] MS_SHORT  = MS_W'(PULSE_MIN_SHORT_MS);
   localparam logic [MS_W-1:0] MS_LONG   = MS_W'(PULSE_MIN_LONG_MS);
   localparam logic [MS_W-1:0] MS_MAX    = MS_W'(PULSE_MAX_MS);
   localparam logic [MS_W-1:0] MS_SAT    = MS_W'(PULSE_MAX_MS + 1);
   localparam int          TICK_W        = 16;

   // ==========================================================
   // Register map, byte addresses.
   localparam int          ADDR_W        = 12;
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK = 12'h00C;

   // ==========================================================
   // Control register fields.
   localparam int          CTRL_W        = 5;
   localparam int          CTRL_LOCK     = 0;
   localparam int          CTRL_HALT_EN  = 1;
   localparam int          CTRL_UP_EN    = 2;
   localparam int          CTRL_AUX_EN   = 3;
   localparam int          CTRL_LONG     = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h01;

   // ==========================================================
   // Status register fields.
   localparam int          ST_ENABLE     = 0;
   localparam int          ST_PENDING    = 1;
   localparam int          ST_NEED       = 2;
   localparam int          ST_FSM_LSB    = 4;
   localparam int          ST_PIN_LSB    = 8;

   // ==========================================================
   // Interrupt event bits.
   localparam int          EV_W          = 5;
   localparam int          EV_EN_RISE    = 0;
   localparam int          EV_EN_FALL    = 1;
   localparam int          EV_PEND_RISE  = 2;
   localparam int          EV_PULSE_OK   = 3;
   localparam int          EV_PULSE_BAD  = 4;
   localparam logic [EV_W-1:0] EV_RESET  = 5'h00;

   // ==========================================================
   // Pin carrier and press states.
   localparam int          PIN_W         = 7;

   typedef struct packed {
      logic start_cmd;
      logic halt_req;
      logic permit_main;
      logic permit_aux;
      logic top_center;
      logic upstroke;
      logic reset_btn;
   } pae_pins_t;

   localparam int          FSM_W         = 3;

   typedef enum logic [FSM_W-1:0] {
      PAE_IDLE = 3'h1,
      PAE_RUN  = 3'h2,
      PAE_DEFER = 3'h4
   } pae_state_t;

endpackage

// >>> rtl/pae_top.sv
// Behaviour
// - Lock off: restart needs no reset pulse.
// - Lock on: reset needed after start-up, stops.
// - Reset-pending only while main permit high, and auxiliary permit too if enabled.
// - Valid pulse: high between minimum and 30 s.
// - After reset, enable needs new start edge.
// - Stop request: halt rise if configured, else start fall.
// - Start edge enables only when all conditions hold.
// - Upstroke low: stop request drops enable now.
// - Upstroke high, not at top: defer to top rise/upstroke fall.
// - No upstroke input: stop at next top rise.
// - Stop with lock raises reset-pending together.
// - Upstroke high, not at top: stop accepted, enable kept.
// - Main permit low forces enable low now.
// - Auxiliary permit checked only before enabling.
// - Halt input evaluated only when configured.
// - Enable and reset-pending never both high.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps

module pae_top #(
   parameter int unsigned TICK_CYCLES = pae_pkg::MS_CYCLES
) (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [pae_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire pae_pkg::pae_pins_t            pins,
   output logic                               press_enable,
   output logic                               reset_pending,
   output logic                               irq
);

   // ==========================================================
   // Input synchronisers and filtered levels.
   logic [pae_pkg::PIN_W-1:0] sync1;
   logic [pae_pkg::PIN_W-1:0] sync2;
   logic [pae_pkg::PIN_W-1:0] sync3;
   logic [pae_pkg::PIN_W-1:0] level;
   logic [pae_pkg::PIN_W-1:0] level_prev;
   logic [pae_pkg::PIN_W-1:0] next_level;
   pae_pkg::pae_pins_t        cur;
   pae_pkg::pae_pins_t        prv;

   always_comb begin
      // A change counts once the second and third stages agree.
      next_level = level;
      for (int i = 0; i < pae_pkg::PIN_W; i++) begin
         if (sync2[i] == sync3[i]) begin
            next_level[i] = sync3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1      <= '0;
         sync2      <= '0;
         sync3      <= '0;
         level      <= '0;
         level_prev <= '0;
      end else begin
         sync1      <= pins;
         sync2      <= sync1;
         sync3      <= sync2;
         level      <= next_level;
         level_prev <= level;
      end
   end

   assign cur = level;
   assign prv = level_prev;

   // ==========================================================
   // Control register decode.
   logic [pae_pkg::CTRL_W-1:0] ctrl;
   logic                       lock_on;
   logic                       halt_on;
   logic                       up_on;
   logic                       aux_on;

   assign lock_on = ctrl[pae_pkg::CTRL_LOCK];
   assign halt_on = ctrl[pae_pkg::CTRL_HALT_EN];
   assign up_on   = ctrl[pae_pkg::CTRL_UP_EN];
   assign aux_on  = ctrl[pae_pkg::CTRL_AUX_EN];

   function automatic logic rise(input logic now, input logic was);
      rise = now && !was;
   endfunction

   function automatic logic fall(input logic now, input logic was);
      fall = !now && was;
   endfunction

   // ==========================================================
   // Millisecond tick and reset pulse timer.
   logic [pae_pkg::TICK_W-1:0] tick_cnt;
   logic [pae_pkg::TICK_W-1:0] next_tick_cnt;
   logic [pae_pkg::MS_W-1:0]   ms_cnt;
   logic [pae_pkg::MS_W-1:0]   next_ms_cnt;
   logic [pae_pkg::MS_W-1:0]   ms_min;
   logic                       pulse_end;
   logic                       pulse_ok;
   logic                       pulse_bad;

   always_comb begin
      next_tick_cnt = tick_cnt;
      next_ms_cnt   = ms_cnt;
      ms_min        = ctrl[pae_pkg::CTRL_LONG] ? pae_pkg::MS_LONG : pae_pkg::MS_SHORT;
      pulse_end     = fall(cur.reset_btn, prv.reset_btn);
      pulse_ok      = pulse_end && (ms_cnt >= ms_min) && (ms_cnt <= pae_pkg::MS_MAX);
      pulse_bad     = pulse_end && !pulse_ok;
      if (!cur.reset_btn) begin
         next_tick_cnt = '0;
         next_ms_cnt   = '0;
      end else if (tick_cnt == pae_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         if (ms_cnt != pae_pkg::MS_SAT) begin
            next_ms_cnt = ms_cnt + 1'b1;
         end
      end else begin
         next_tick_cnt = tick_cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         ms_cnt   <= '0;
      end else begin
         tick_cnt <= next_tick_cnt;
         ms_cnt   <= next_ms_cnt;
      end
   end

   // ==========================================================
   // Press enable state machine.
   pae_pkg::pae_state_t state;
   pae_pkg::pae_state_t next_state;
   logic                need_reset;
   logic                next_need_reset;
   logic                next_press_enable;
   logic                next_reset_pending;
   logic                permits_ok;
   logic                stop_req;
   logic                start_ok;
   logic                do_stop;

   always_comb begin
      next_state      = state;
      next_need_reset = need_reset;
      do_stop         = 1'b0;
      permits_ok      = cur.permit_main && (!aux_on || cur.permit_aux);
      stop_req        = halt_on ? rise(cur.halt_req, prv.halt_req)
                                : fall(cur.start_cmd, prv.start_cmd);
      start_ok        = rise(cur.start_cmd, prv.start_cmd) && permits_ok
                        && !(halt_on && cur.halt_req)
                        && !(lock_on && need_reset);
      if (pulse_ok && reset_pending) begin
         next_need_reset = 1'b0;
      end
      case (state)
         pae_pkg::PAE_IDLE: begin
            if (start_ok) begin
               next_state = pae_pkg::PAE_RUN;
            end
         end
         pae_pkg::PAE_RUN: begin
            if (stop_req) begin
               if (up_on && (!cur.upstroke || cur.top_center)) begin
                  do_stop = 1'b1;
               end else begin
                  next_state = pae_pkg::PAE_DEFER;
               end
            end
         end
         pae_pkg::PAE_DEFER: begin
            if (rise(cur.top_center, prv.top_center)) begin
               do_stop = 1'b1;
            end else if (up_on && !cur.upstroke) begin
               do_stop = 1'b1;
            end
         end
         default: begin
            next_state = pae_pkg::PAE_IDLE;
         end
      endcase
      if (do_stop) begin
         next_state      = pae_pkg::PAE_IDLE;
         next_need_reset = 1'b1;
      end
      if (!cur.permit_main) begin
         if (state != pae_pkg::PAE_IDLE) begin
            next_need_reset = 1'b1;
         end
         next_state = pae_pkg::PAE_IDLE;
      end
      next_press_enable  = (next_state != pae_pkg::PAE_IDLE);
      next_reset_pending = lock_on && next_need_reset && permits_ok
                           && !next_press_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state         <= pae_pkg::PAE_IDLE;
         need_reset    <= 1'b1;
         press_enable  <= 1'b0;
         reset_pending <= 1'b0;
      end else begin
         state         <= next_state;
         need_reset    <= next_need_reset;
         press_enable  <= next_press_enable;
         reset_pending <= next_reset_pending;
      end
   end

   // ==========================================================
   // APB slave, registers and interrupt.
   logic [pae_pkg::CTRL_W-1:0] next_ctrl;
   logic [pae_pkg::EV_W-1:0]   int_stat;
   logic [pae_pkg::EV_W-1:0]   next_int_stat;
   logic [pae_pkg::EV_W-1:0]   int_mask;
   logic [pae_pkg::EV_W-1:0]   next_int_mask;
   logic [pae_pkg::EV_W-1:0]   events;
   logic [31:0]                next_prdata;
   logic                       next_pready;
   logic                       next_pslverr;
   logic                       next_irq;
   logic                       setup;
   logic                       wr;
   logic                       mapped;

   always_comb begin
      setup  = psel && !penable;
      wr     = psel && penable && pready && pwrite;
      mapped = (paddr == pae_pkg::OFF_CTRL) || (paddr == pae_pkg::OFF_STATUS)
               || (paddr == pae_pkg::OFF_INT_STAT) || (paddr == pae_pkg::OFF_INT_MASK);
      events = '0;
      events[pae_pkg::EV_EN_RISE]   = next_press_enable && !press_enable;
      events[pae_pkg::EV_EN_FALL]   = !next_press_enable && press_enable;
      events[pae_pkg::EV_PEND_RISE] = next_reset_pending && !reset_pending;
      events[pae_pkg::EV_PULSE_OK]  = pulse_ok;
      events[pae_pkg::EV_PULSE_BAD] = pulse_bad;
      next_ctrl     = ctrl;
      next_int_mask = int_mask;
      next_int_stat = int_stat;
      if (wr && (paddr == pae_pkg::OFF_CTRL)) begin
         next_ctrl = pwdata[pae_pkg::CTRL_W-1:0];
      end
      if (wr && (paddr == pae_pkg::OFF_INT_MASK)) begin
         next_int_mask = pwdata[pae_pkg::EV_W-1:0];
      end
      if (wr && (paddr == pae_pkg::OFF_INT_STAT)) begin
         next_int_stat = int_stat & ~pwdata[pae_pkg::EV_W-1:0];
      end
      next_int_stat = next_int_stat | events;
      next_irq      = |(next_int_stat & next_int_mask);
      next_pready   = setup;
      next_pslverr  = setup && !mapped;
      next_prdata   = '0;
      if (setup && !pwrite) begin
         case (paddr)
            pae_pkg::OFF_CTRL: begin
               next_prdata[pae_pkg::CTRL_W-1:0] = ctrl;
            end
            pae_pkg::OFF_STATUS: begin
               next_prdata[pae_pkg::ST_ENABLE]  = press_enable;
               next_prdata[pae_pkg::ST_PENDING] = reset_pending;
               next_prdata[pae_pkg::ST_NEED]    = need_reset;
               next_prdata[pae_pkg::ST_FSM_LSB +: pae_pkg::FSM_W] = state;
               next_prdata[pae_pkg::ST_PIN_LSB +: pae_pkg::PIN_W] = level;
            end
            pae_pkg::OFF_INT_STAT: begin
               next_prdata[pae_pkg::EV_W-1:0] = int_stat;
            end
            pae_pkg::OFF_INT_MASK: begin
               next_prdata[pae_pkg::EV_W-1:0] = int_mask;
            end
            default: begin
               next_prdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= pae_pkg::CTRL_RESET;
         int_stat <= pae_pkg::EV_RESET;
         int_mask <= pae_pkg::EV_RESET;
         prdata   <= '0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         irq      <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         int_stat <= next_int_stat;
         int_mask <= next_int_mask;
         prdata   <= next_prdata;
         pready   <= next_pready;
         pslverr  <= next_pslverr;
         irq      <= next_irq;
      end
   end

endmodule

// >>> testbench/pae_top_properties.sv
`timescale 1ns/1ps
// ==========
// Port checker of the press enable block.
module pae_top_properties (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [11:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire pae_pkg::pae_pins_t pins,
   input wire logic               press_enable,
   input wire logic               reset_pending
);
   logic [4:0] ctrl;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 5'h01;
      end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
         ctrl <= pwdata[4:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_excl; !(press_enable && reset_pending); endproperty
   a_excl: assert property (p_excl) else $error("enable with pending");
   property p_main; !pins.permit_main [*7] |-> !press_enable; endproperty
   a_main: assert property (p_main) else $error("enable without permit");
   property p_perm; !pins.permit_main [*7] |-> !reset_pending; endproperty
   a_perm: assert property (p_perm) else $error("pending without permit");
   property p_fresh; $rose(press_enable) |-> !$past(reset_pending); endproperty
   a_fresh: assert property (p_fresh) else $error("enable before reset");
   property p_start;
      $rose(press_enable) |-> pins.start_cmd && pins.permit_main
         && (!ctrl[3] || pins.permit_aux) && !(ctrl[1] && pins.halt_req);
   endproperty
   a_start: assert property (p_start) else $error("enable refused case");
   property p_lock;
      $fell(press_enable) && ctrl[0] && pins.permit_main && pins.permit_aux |-> reset_pending;
   endproperty
   a_lock: assert property (p_lock) else $error("stop without pending");
   property p_free; !ctrl[0] [*3] |-> !reset_pending; endproperty
   a_free: assert property (p_free) else $error("pending with lock off");
   property p_top; $fell(press_enable) && !ctrl[2] && pins.permit_main |-> pins.top_center;
   endproperty
   a_top: assert property (p_top) else $error("stop away from top");
endmodule

bind pae_top pae_top_properties chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pins(pins),
   .press_enable(press_enable), .reset_pending(reset_pending)
);

// >>> testbench/pae_press_model.sv
`timescale 1ns/1ps
// ==========
// Press motion: the stroke advances only while the drive is enabled.
module pae_press_model (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               press_enable,
   input wire pae_pkg::pae_pins_t cmd,
   output pae_pkg::pae_pins_t     pins
);
   logic [5:0] phase;
   logic [5:0] next_phase;
   always_comb begin
      next_phase = press_enable ? phase + 6'h01 : phase;
      pins = cmd;
      pins.top_center = phase < 6'h10;
      pins.upstroke = phase >= 6'h28;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 6'h00;
      end else begin
         phase <= next_phase;
      end
   end
endmodule

// >>> testbench/pae_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", n, e, s); end end
`define TILL(c) while (!(c)) @(posedge pclk);
module pae_top_tb;
   // ==========
   // Signals, rows and instances.
   localparam int TK = 4;
   typedef struct packed {
      logic [4:0] ctrl;
      logic [6:0] pin;
      logic       en;
   } pae_row_t;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic               press_enable, reset_pending, irq;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, rd;
   pae_pkg::pae_pins_t cmd, pins;
   int                 err_total, compares, cycles;
   pae_row_t           rows [7] = '{
      '{5'h00, 7'h18, 1'b1}, '{5'h00, 7'h08, 1'b0}, '{5'h08, 7'h10, 1'b0},
      '{5'h00, 7'h10, 1'b1}, '{5'h02, 7'h38, 1'b0}, '{5'h00, 7'h38, 1'b1},
      '{5'h02, 7'h18, 1'b1}};
   pae_top #(.TICK_CYCLES(TK)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .press_enable(press_enable), .reset_pending(reset_pending), .irq(irq));
   pae_press_model model_u (
      .pclk(pclk), .presetn(presetn), .press_enable(press_enable), .cmd(cmd), .pins(pins));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end
   // ==========
   // Tasks.
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int ms);
      cmd.reset_btn <= 1'b1;
      cyc(ms * TK);
      cmd.reset_btn <= 1'b0;
      cyc(12);
   endtask
   task automatic test_done();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========
   // Main sequence.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cmd = 7'h18;
      cyc(12);
      presetn <= 1'b1;
      cyc(2);
      for (int r = 0; r < 7; r++) begin
         apb(1'b1, 12'h000, {27'h0, rows[r].ctrl});
         cmd <= rows[r].pin;
         cyc(8);
         cmd.start_cmd <= 1'b1;
         cyc(10);
         `CHK("enable", rows[r].en, press_enable)
         `CHK("pending", 1'b0, reset_pending)
         cmd <= 7'h00;
         cyc(8);
         `CHK("enable", 1'b0, press_enable)
      end
      apb(1'b1, 12'h000, 32'h00000008);
      cmd <= 7'h18;
      cyc(8);
      cmd.start_cmd <= 1'b1;
      cyc(10);
      cmd.permit_aux <= 1'b0;
      cyc(8);
      `CHK("enable", 1'b1, press_enable)
      cmd <= 7'h00;
      cyc(8);
      presetn <= 1'b0;
      cyc(3);
      `CHK("enable", 1'b0, press_enable)
      presetn <= 1'b1;
      cyc(8);
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl", 32'h00000001, rd)
      `CHK("pending", 1'b0, reset_pending)
      cmd <= 7'h18;
      cyc(8);
      `CHK("pending", 1'b1, reset_pending)
      cmd.start_cmd <= 1'b1;
      cyc(10);
      `CHK("enable", 1'b0, press_enable)
      pulse(50);
      `CHK("pending", 1'b1, reset_pending)
      pulse(120);
      `CHK("pending", 1'b0, reset_pending)
      `CHK("enable", 1'b0, press_enable)
      cmd.start_cmd <= 1'b0;
      cyc(8);
      cmd.start_cmd <= 1'b1;
      cyc(10);
      `CHK("enable", 1'b1, press_enable)
      `TILL(pins.upstroke)
      cmd.start_cmd <= 1'b0;
      cyc(8);
      `CHK("enable", 1'b1, press_enable)
      `TILL(!press_enable)
      `CHK("top", 1'b1, pins.top_center)
      `CHK("pending", 1'b1, reset_pending)
      apb(1'b1, 12'h000, 32'h00000017);
      pulse(120);
      `CHK("pending", 1'b1, reset_pending)
      pulse(400);
      `CHK("pending", 1'b0, reset_pending)
      cmd.start_cmd <= 1'b1;
      cyc(10);
      `CHK("enable", 1'b1, press_enable)
      cmd.start_cmd <= 1'b0;
      cyc(8);
      `CHK("enable", 1'b1, press_enable)
      `TILL(pins.upstroke)
      cmd.halt_req <= 1'b1;
      cyc(8);
      `CHK("enable", 1'b1, press_enable)
      `TILL(!press_enable)
      `CHK("top", 1'b1, pins.top_center)
      `CHK("pending", 1'b1, reset_pending)
      cmd.halt_req <= 1'b0;
      pulse(400);
      cmd.start_cmd <= 1'b1;
      cyc(10);
      `CHK("enable", 1'b1, press_enable)
      `TILL(!pins.top_center)
      cmd.halt_req <= 1'b1;
      cyc(8);
      `CHK("enable", 1'b0, press_enable)
      apb(1'b0, 12'h008, 32'h0);
      `CHK("int_stat", 32'h0000001F, rd)
      `CHK("irq", 1'b0, irq)
      apb(1'b1, 12'h00C, 32'h00000002);
      cyc(2);
      `CHK("irq", 1'b1, irq)
      apb(1'b1, 12'h008, 32'h0000001F);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("pslverr", 1'b1, serr)
      `CHK("rdata", 32'h0, rd)
      test_done();
   end
endmodule
